// *** src/event_slot_and_pull_cfg_regs.sv ***
// Event readout slots and row pull select registers behind APB
//
// Behaviour
// - Slots four-nine at 0x06-0x0B, bit7 state
// - Bits 6:0 hold read-only event identifier
// - Codes 00/01/10: 300k up, 300k down, 100k up
// - Code 11 switches all resistors off
// - Low register 0x17 holds rows three..zero
// - High register 0x18: row5 3:2, row4 1:0
// - Row five field only on six-row variant
// - Low register reset value depends on variant
// - High register reset value depends on variant
// - State bit: pressed/active one, released/inactive zero
// - Identifier zero none, keys, inputs, logic
`timescale 1ns/10ps
`default_nettype none
module event_slot_and_pull_cfg_regs
  import keypad_regs_pkg::*;
#(
  parameter variant_type variant = variant_base
)
(
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [slot_count-1:0]      slot_load,
  input  wire logic [slot_count-1:0][7:0] slot_data,
  output logic      [row_count-1:0]       pull_up_weak,
  output logic      [row_count-1:0]       pull_down_weak,
  output logic      [row_count-1:0]       pull_up_strong,
  output logic                            irq
);

  // ==========================================================
  // Elaboration-time constants for the chosen variant
  localparam logic [7:0] low_rst  = low_reset(variant);
  localparam logic [7:0] high_rst = high_reset(variant);
  localparam logic       six_row  = (variant == variant_six_row);
  // Row five bits only take writes where the sixth pin exists
  localparam logic [7:0] high_wmask =
    six_row ? high_mask_six : high_mask_base;

  // ==========================================================
  // Storage
  logic [slot_count-1:0][7:0] slot_reg;  // Slot four..nine bytes
  logic [7:0]                 pull_low;  // Rows three..zero
  logic [7:0]                 pull_high; // Rows five and four
  logic [ev_width-1:0]        status;    // Sticky event flags
  logic [ev_width-1:0]        mask;      // Interrupt enables

  // Next values
  logic [ev_width-1:0]        next_status;
  logic [7:0]                 next_high;

  // ==========================================================
  // APB phase decode
  wire logic setup;   // First cycle of a transfer
  wire logic access;  // Second cycle, completes at once
  wire logic lane_ok; // Low byte lane enabled
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign lane_ok = pstrb[0];

  // Slave never inserts wait states
  assign pready = 1'b1;

  // ==========================================================
  // Address decode
  wire logic [slot_count-1:0] hit_slot; // One per readout slot
  wire logic hit_low;
  wire logic hit_high;
  wire logic hit_status;
  wire logic hit_mask;
  wire logic addr_hit;

  // Slots sit at consecutive indices from slot four upward
  for (genvar s = 0; s < slot_count; s++) begin : g_hit
    assign hit_slot[s] =
      (paddr == byte_addr(idx_slot_four + 8'(s)));
  end

  assign hit_low    = (paddr == byte_addr(idx_pull_low));
  assign hit_high   = (paddr == byte_addr(idx_pull_high));
  assign hit_status = (paddr == byte_addr(idx_irq_status));
  assign hit_mask   = (paddr == byte_addr(idx_irq_mask));
  assign addr_hit   = (|hit_slot) | hit_low | hit_high
                    | hit_status | hit_mask;

  // Transfer completions
  wire logic wr_fire; // Write to a mapped register
  wire logic rd_fire; // Read of a mapped register
  assign wr_fire = access & pready & pwrite & addr_hit;
  assign rd_fire = access & pready & ~pwrite & addr_hit;

  // Unmapped or misaligned addresses answer with an error
  assign pslverr = access & ~addr_hit;

  // Write strobes per writable register
  wire logic wr_low;
  wire logic wr_high;
  wire logic wr_mask;
  assign wr_low  = wr_fire & hit_low & lane_ok;
  assign wr_high = wr_fire & hit_high & lane_ok;
  assign wr_mask = wr_fire & hit_mask & lane_ok;

  // ==========================================================
  // Read data selection
  logic [7:0] slot_byte; // Selected slot byte or zero

  // Slot bytes are read-only; state and identifier pass whole
  always_comb begin
    slot_byte = 8'h00;
    for (int s = 0; s < slot_count; s++) begin
      if (hit_slot[s]) begin
        slot_byte = slot_reg[s];
      end
    end
  end

  wire logic [7:0] read_byte;
  assign read_byte = slot_byte
    | ({8{hit_low}}    & pull_low)
    | ({8{hit_high}}   & pull_high)
    | ({8{hit_status}} & {4'h0, status})
    | ({8{hit_mask}}   & {4'h0, mask});

  // Read data is captured in the setup cycle so that prdata is a
  // flop; the captured status also names the bits a read clears
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata <= {24'h00_0000, read_byte};
    end
  end

  // ==========================================================
  // Event slot capture
  // Each slot byte is loaded by the event store beside this
  // block; software writes never reach it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_reg <= '0;
    end else begin
      for (int s = 0; s < slot_count; s++) begin
        if (slot_load[s]) begin
          slot_reg[s] <= slot_data[s];
        end
      end
    end
  end

  // ==========================================================
  // Event classification
  // Keys raise press or release, inputs and logic raise active or
  // idle; identifier zero and unused codes raise nothing
  logic [ev_width-1:0] new_events;

  always_comb begin
    new_events = '0;
    for (int s = 0; s < slot_count; s++) begin
      if (slot_load[s]) begin
        new_events = new_events | slot_event(slot_data[s]);
      end
    end
  end

  // ==========================================================
  // Sticky status, cleared by a read
  // Only bits that the read actually returned are cleared, so an
  // event between capture and completion survives; set wins
  wire logic [ev_width-1:0] read_clear;
  assign read_clear = (rd_fire & hit_status)
                    ? prdata[ev_width-1:0] : '0;
  assign next_status = (status & ~read_clear) | new_events;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // Mask register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask <= '0;
    end else if (wr_mask) begin
      mask <= pwdata[ev_width-1:0];
    end
  end

  // Level interrupt while any unmasked flag is set
  assign irq = |(status & mask);

  // ==========================================================
  // Pull select registers
  // Reserved bits and, off the six-row variant, the row five
  // field keep their reset value whatever is written
  assign next_high = (pull_high & ~high_wmask)
                   | (pwdata[7:0] & high_wmask);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pull_low <= low_rst;
    end else if (wr_low) begin
      pull_low <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pull_high <= high_rst;
    end else if (wr_high) begin
      pull_high <= next_high;
    end
  end

  // ==========================================================
  // Pull code routing and decode
  pull_sel_if pins ();

  // Rows three..zero sit two bits each, high row first
  assign pins.sel[0] = pull_low[1:0];
  assign pins.sel[1] = pull_low[3:2];
  assign pins.sel[2] = pull_low[5:4];
  assign pins.sel[3] = pull_low[7:6];
  assign pins.sel[4] = pull_high[1:0];
  // A missing sixth pin is held with every resistor off
  assign pins.sel[5] = six_row ? pull_high[3:2] : pull_off;

  pull_decoder u_decoder (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pins     (pins)
  );

  assign pull_up_weak   = pins.up_weak;
  assign pull_down_weak = pins.down_weak;
  assign pull_up_strong = pins.up_strong;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_slot_capture: assert property (
    slot_load[1] |=> slot_reg[1] == $past(slot_data[1]))
    else $error("slot byte not captured on load");

  a_slot_state_read: assert property (
    (setup && !pwrite && hit_slot[5]) |=>
      prdata[7:0] == $past(slot_reg[5]))
    else $error("slot nine read returned wrong byte");

  a_slot_read_only: assert property (
    (wr_fire && (|hit_slot) && !(|slot_load)) |=>
      $stable(slot_reg))
    else $error("write altered a read-only slot");

  a_low_write: assert property (
    wr_low |=> pull_low == $past(pwdata[7:0]))
    else $error("low pull register write lost");

  a_row_four_write: assert property (
    wr_high |=> pull_high[1:0] == $past(pwdata[1:0]))
    else $error("row four pull field write lost");

  a_row_five_frozen: assert property (
    (wr_high && !six_row) |=> $stable(pull_high[3:2]))
    else $error("row five field changed without sixth pin");

  a_reserved_zero: assert property (
    (wr_high ##1 1'b1) |-> pull_high[7:4] == 4'h0)
    else $error("reserved pull bits became set");

  a_low_reset: assert property (
    $fell(sys_rst) |-> pull_low == low_rst)
    else $error("low pull register reset value wrong");

  a_high_reset: assert property (
    $fell(sys_rst) |-> pull_high == high_rst)
    else $error("high pull register reset value wrong");

  a_key_press_flag: assert property (
    (slot_load == 6'h01 && slot_data[0] == 8'h81) |=>
      status[ev_key_press] && !status[ev_key_release] ||
      $past(status[ev_key_release]))
    else $error("key press did not raise its flag");

  a_no_event_quiet: assert property (
    (slot_load == 6'h01 && slot_data[0][6:0] == ident_none &&
     status == 4'h0) |=> status == 4'h0)
    else $error("empty identifier raised an event flag");

  a_read_clears: assert property (
    (rd_fire && hit_status && slot_load == 6'h00 &&
     $past(slot_load) == 6'h00) |=> status == 4'h0)
    else $error("status read did not clear flags");

  // Only the six-row part lets software move the row five code
  a_row_five_write: assert property (
    (wr_high && six_row) |=> pull_high[3:2] == $past(pwdata[3:2]))
    else $error("row five field write lost on six-row part");

  // A pin that is not bonded out must never load the line
  a_row_five_off: assert property (
    !six_row |->
      !(pull_up_weak[5] || pull_down_weak[5] || pull_up_strong[5]))
    else $error("missing sixth pin has a resistor on");

  a_high_rsvd_read: assert property (
    (setup && !pwrite && hit_high) |=> prdata[7:4] == 4'h0)
    else $error("reserved pull bits read back nonzero");

  a_slot_ident_read: assert property (
    (setup && !pwrite && hit_slot[0]) |=>
      prdata[6:0] == $past(slot_reg[0][6:0]))
    else $error("slot four identifier read wrong");

  a_slot_bit_seven: assert property (
    (setup && !pwrite && hit_slot[2]) |=>
      prdata[state_bit] == $past(slot_reg[2][state_bit]))
    else $error("slot six state bit read wrong");

  a_key_release_flag: assert property (
    (slot_load == 6'h02 && slot_data[1] == 8'h01) |=>
      status[ev_key_release])
    else $error("key release did not raise its flag");

  // Identifier 48 is the logic block output, an active event here
  a_logic_active: assert property (
    (slot_load == 6'h10 && slot_data[4] == 8'hb0) |=>
      status[ev_aux_active])
    else $error("logic block event did not raise its flag");

endmodule
`default_nettype wire

// *** src/keypad_regs_pkg.sv ***
// Shared constants and helpers for the event slot and pull select slice
`default_nettype none
package keypad_regs_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] idx_slot_four  = 8'h06;
  localparam logic [7:0] idx_slot_five  = 8'h07;
  localparam logic [7:0] idx_slot_six   = 8'h08;
  localparam logic [7:0] idx_slot_seven = 8'h09;
  localparam logic [7:0] idx_slot_eight = 8'h0a;
  localparam logic [7:0] idx_slot_nine  = 8'h0b;
  localparam logic [7:0] idx_pull_low   = 8'h17;
  localparam logic [7:0] idx_pull_high  = 8'h18;
  localparam logic [7:0] idx_irq_status = 8'h1e;
  localparam logic [7:0] idx_irq_mask   = 8'h1f;

  // ==========================================================
  // Sizes and field positions
  localparam int slot_count = 6;
  localparam int row_count  = 6;
  localparam int state_bit  = 7;
  localparam int ident_msb  = 6;
  localparam int ev_width   = 4;
  localparam int ev_key_press   = 0;
  localparam int ev_key_release = 1;
  localparam int ev_aux_active  = 2;
  localparam int ev_aux_idle    = 3;

  // ==========================================================
  // Pull codes and identifier ranges
  localparam logic [1:0] pull_up_300   = 2'h0;
  localparam logic [1:0] pull_down_300 = 2'h1;
  localparam logic [1:0] pull_up_100   = 2'h2;
  localparam logic [1:0] pull_off      = 2'h3;
  localparam logic [6:0] ident_none = 7'h00;
  localparam logic [6:0] key_first  = 7'h01;
  localparam logic [6:0] key_last   = 7'h24;
  localparam logic [6:0] aux_first  = 7'h25;
  localparam logic [6:0] aux_last   = 7'h30;

  // ==========================================================
  // Reset values and write masks
  localparam logic [7:0] pull_rst_base  = 8'h00;
  localparam logic [7:0] low_rst_alt_a  = 8'hc3;
  localparam logic [7:0] low_rst_alt_b  = 8'h55;
  localparam logic [7:0] high_rst_alt_a = 8'h03;
  localparam logic [7:0] high_rst_alt_b = 8'h05;
  localparam logic [7:0] high_mask_six  = 8'h0f;
  localparam logic [7:0] high_mask_base = 8'h03;

  typedef enum {variant_base, variant_six_row, variant_alt_a,
                variant_alt_b} variant_type;

  // Byte address of a register index
  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    return {idx[5:0], 2'h0};
  endfunction

  // Event class bits raised by one loaded slot byte
  function automatic logic [3:0] slot_event(input logic [7:0] d);
    logic key;
    logic aux;
    logic st;
    key = (d[ident_msb:0] >= key_first) && (d[ident_msb:0] <= key_last);
    aux = (d[ident_msb:0] >= aux_first) && (d[ident_msb:0] <= aux_last);
    st  = d[state_bit];
    slot_event = {aux & ~st, aux & st, key & ~st, key & st};
  endfunction

  function automatic logic [7:0] low_reset(input variant_type v);
    unique case (v)
      variant_alt_a: low_reset = low_rst_alt_a;
      variant_alt_b: low_reset = low_rst_alt_b;
      variant_base, variant_six_row: low_reset = pull_rst_base;
    endcase
  endfunction

  function automatic logic [7:0] high_reset(input variant_type v);
    unique case (v)
      variant_alt_a: high_reset = high_rst_alt_a;
      variant_alt_b: high_reset = high_rst_alt_b;
      variant_base, variant_six_row: high_reset = pull_rst_base;
    endcase
  endfunction

endpackage
`default_nettype wire

// *** src/pull_sel_if.sv ***
// Carrier between the register slice and its pull decoder
`timescale 1ns/10ps
`default_nettype none
interface pull_sel_if
  import keypad_regs_pkg::*;
  ;
  logic [row_count-1:0][1:0] sel;       // Pull code per row pin
  logic [row_count-1:0]      up_weak;   // 300 k pull-up on
  logic [row_count-1:0]      down_weak; // 300 k pull-down on
  logic [row_count-1:0]      up_strong; // 100 k pull-up on
  modport regs (output sel, input up_weak, down_weak, up_strong);
  modport dec  (input sel, output up_weak, down_weak, up_strong);
endinterface
`default_nettype wire

// *** src/pull_decoder.sv ***
// Decoder from row pull codes to resistor enables
`timescale 1ns/10ps
`default_nettype none
module pull_decoder
  import keypad_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  pull_sel_if.dec  pins
);

  // ==========================================================
  // Code decode, result is {up_strong, down_weak, up_weak}
  function automatic logic [2:0] decode_pull(input logic [1:0] code);
    unique case (code)
      pull_up_300:   decode_pull = 3'h1;
      pull_down_300: decode_pull = 3'h2;
      pull_up_100:   decode_pull = 3'h4;
      pull_off:      decode_pull = 3'h0;
    endcase
  endfunction

  // ==========================================================
  // One decoder per row; at most one resistor is ever on
  for (genvar r = 0; r < row_count; r++) begin : g_row
    wire logic [2:0] dec_bits;
    assign dec_bits           = decode_pull(pins.sel[r]);
    assign pins.up_weak[r]   = dec_bits[0];
    assign pins.down_weak[r] = dec_bits[1];
    assign pins.up_strong[r] = dec_bits[2];
  end

  // ==========================================================
  // Checks on the decode
  a_code_down_weak: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (pins.sel[0] == pull_down_300) |->
      pins.down_weak[0] && !pins.up_weak[0] && !pins.up_strong[0])
    else $error("row zero pull-down code mis-decoded");

  a_code_strong_up: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (pins.sel[3] == pull_up_100) |->
      pins.up_strong[3] && !pins.up_weak[3] && !pins.down_weak[3])
    else $error("row three strong pull-up code mis-decoded");

  a_code_all_off: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (pins.sel[4] == pull_off) |->
      !(pins.up_weak[4] || pins.down_weak[4] || pins.up_strong[4]))
    else $error("row four off code left a resistor on");

endmodule
`default_nettype wire

// *** bench/apb_host.sv ***
// Bus master model standing in for the host processor on the register bus
`timescale 1ns/10ps
`default_nettype none
module apb_host (
  input  wire logic        core_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             done,
  output logic [32:0]      got
);
  // ==========================================================
  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    done    = 1'b0;
    got     = 33'h0;
  end

  // ==========================================================
  // One transfer: setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d, input logic [3:0] s);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait for the answer; only the bench watchdog ends a hang
    do @(posedge core_clk); while (pready !== 1'b1);
    done    <= ~wr;
    got     <= {pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a slave cannot lean on stale values
    paddr   <= ~a;
    pwdata  <= ~{24'h0, d};
    @(posedge core_clk);
    done    <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_event_slot_and_pull_cfg_regs.sv ***
// Self-checking bench for the event slot and pull select registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  fail_count++; $display("unexpected t=%0t got=%h exp=%h", $time, a, b); \
  end end
module tb_event_slot_and_pull_cfg_regs
  import keypad_regs_pkg::*;
;
  // ==========================================================
  // Signals
  logic                       core_clk;
  logic                       sys_rst;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [7:0]                 paddr;
  logic [31:0]                pwdata;
  logic [3:0]                 pstrb;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [slot_count-1:0]      slot_load;
  logic [slot_count-1:0][7:0] slot_data;
  logic [row_count-1:0]       pull_up_weak;
  logic [row_count-1:0]       pull_down_weak;
  logic [row_count-1:0]       pull_up_strong;
  logic                       irq;
  logic [31:0]                six_prdata;    // Six-row part read data
  logic [row_count-1:0]       six_up_weak;   // Six-row part enables
  logic [row_count-1:0]       six_down_weak;
  logic [row_count-1:0]       six_up_strong;
  logic                       done;
  logic [32:0]                got;
  logic [32:0]                exp_q[$];   // Expected read results
  logic [32:0]                head;       // Oldest expectation
  int                         fail_count = 0;
  int                         samples_checked = 0;

  // ==========================================================
  // Clock and instances
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Alternate variant: nonzero resets and a fixed row five field
  event_slot_and_pull_cfg_regs #(.variant(variant_alt_b))
    event_slot_and_pull_cfg_regs_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slot_load(slot_load), .slot_data(slot_data),
    .pull_up_weak(pull_up_weak), .pull_down_weak(pull_down_weak),
    .pull_up_strong(pull_up_strong), .irq(irq));

  apb_host apb_host_i (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .done(done),
    .got(got));

  // Six-row variant on the same bus: its row five field is live
  event_slot_and_pull_cfg_regs #(.variant(variant_six_row))
    event_slot_and_pull_cfg_regs_six_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(six_prdata),
    .pready(), .pslverr(), .slot_load(slot_load), .slot_data(slot_data),
    .pull_up_weak(six_up_weak), .pull_down_weak(six_down_weak),
    .pull_up_strong(six_up_strong), .irq());

  // ==========================================================
  // Helpers
  // Event class bits expected from one slot byte
  function automatic logic [3:0] ev(input logic [7:0] v);
    logic key;
    logic aux;
    key = (v[6:0] >= 7'h01) && (v[6:0] <= 7'h24);
    aux = (v[6:0] >= 7'h25) && (v[6:0] <= 7'h30);
    return {aux & ~v[7], aux & v[7], key & ~v[7], key & v[7]};
  endfunction

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb_host_i.xfer(1'b0, a, 8'h00, 4'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    apb_host_i.xfer(1'b1, a, d, s);
  endtask

  // One-cycle load pulse, then let the edge settle
  task automatic load(input int s, input logic [7:0] d);
    @(posedge core_clk);
    slot_load[s] <= 1'b1;
    slot_data[s] <= d;
    @(posedge core_clk);
    slot_load[s] <= 1'b0;
    #1;
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Monitor: each completed read is matched to the oldest note
  always @(posedge core_clk) begin
    if (done === 1'b1) begin
      head = exp_q.pop_front();
      `CHK(got, head)
    end
  end

  // Watchdog: the whole sequence needs well under this span
  initial begin
    #200us;
    fail_count++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [1:0] c;
    logic [3:0] acc;
    logic [6:0] ids[7];
    ids = '{7'h00, 7'h01, 7'h24, 7'h25, 7'h30, 7'h31, 7'h7f};
    void'($urandom(32'h51f098b0));
    sys_rst   = 1'b1;
    slot_load = '0;
    slot_data = '0;
    acc       = 4'h0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK(pull_down_weak, 6'h1f)
    `CHK(irq, 1'b0)
    `CHK(pready, 1'b1)
    `CHK(six_up_weak, 6'h3f)
    rd(8'h5c, {25'h0, 8'h55});
    rd(8'h60, {25'h0, 8'h05});
    // Every pull code on every row, reserved bits written as ones
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(8'h5c, {c, c, c, c}, 4'h1);
      wr(8'h60, {4'hf, c, c}, 4'h1);
      rd(8'h5c, {25'h0, c, c, c, c});
      rd(8'h60, {29'h0, 2'h1, c});
      `CHK(six_prdata, {28'h0, c, c})
      `CHK(six_up_weak, {6{c == 2'h0}})
      `CHK(six_down_weak, {6{c == 2'h1}})
      `CHK(six_up_strong, {6{c == 2'h2}})
      `CHK(pull_up_weak, {1'b0, {5{c == 2'h0}}})
      `CHK(pull_down_weak, {1'b0, {5{c == 2'h1}}})
      `CHK(pull_up_strong, {1'b0, {5{c == 2'h2}}})
    end
    // Mixed fields; a write without the low strobe must not land
    d = 8'($urandom);
    wr(8'h5c, ~d, 4'he);
    wr(8'h5c, d, 4'h1);
    rd(8'h5c, {25'h0, d});
    for (int r = 0; r < 4; r++) begin
      `CHK(pull_up_strong[r], d[2*r+:2] == 2'h2)
      `CHK(pull_down_weak[r], d[2*r+:2] == 2'h1)
    end
    // Slots four to nine: load, read, refuse a write
    for (int s = 0; s < slot_count; s++) begin
      d = 8'($urandom);
      acc = acc | ev(d);
      load(s, d);
      rd(8'h18 + 8'(4 * s), {25'h0, d});
      wr(8'h18 + 8'(4 * s), ~d, 4'hf);
      rd(8'h18 + 8'(4 * s), {25'h0, d});
    end
    rd(8'h78, {29'h0, acc});
    // Identifier classes and both states with all events unmasked
    wr(8'h7c, 8'h0f, 4'h1);
    foreach (ids[k]) begin
      for (int st = 0; st < 2; st++) begin
        d = {st[0], ids[k]};
        load(k % slot_count, d);
        `CHK(irq, |ev(d))
        rd(8'h78, {29'h0, ev(d)});
        `CHK(irq, 1'b0)
      end
    end
    // Masked event stays sticky and shows once unmasked
    wr(8'h7c, 8'h00, 4'h1);
    load(0, 8'h81);
    `CHK(irq, 1'b0)
    wr(8'h7c, 8'h01, 4'h1);
    `CHK(irq, 1'b1)
    rd(8'h78, {29'h0, 4'h1});
    // Unmapped and misaligned places answer with an error
    wr(8'h40, 8'hff, 4'h1);
    rd(8'h40, {1'b1, 32'h0});
    rd(8'h5d, {1'b1, 32'h0});
    repeat (3) @(posedge core_clk);
    `CHK(exp_q.size(), 0)
    wrap_up();
  end
endmodule
`default_nettype wire
